/* File: rtl/ism_top.sv */
/*
 Interrupt status and mask unit of a multi-channel PWM audio
 controller, with APB register access and a styled interrupt pin.
 Assumes event pulses and clip strobes come from pclk logic and
 GPIO pins are asynchronous.
*/
`timescale 1ns/1ps
`include "ism_params.svh"
module ism_top (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire ism_pkg::ism_src_evt_type src_evt,
   input  wire logic [`ISM_CHANS-1:0]   chan_clip,
   input  wire logic [`ISM_GPIOS-1:0]   gpio_pin,
   output logic                         irq_pin_out,
   output logic                         irq_pin_oe
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   ism_pkg::ism_state_type      state_reg;     // Registered state
   ism_pkg::ism_state_type      state_next;    // Next state
   ism_pkg::ism_pin_style_type  style;         // Selected pin style
   logic [5:0]                  idx;           // Word index of paddr
   logic                        rd_setup;      // Read setup cycle
   logic                        wr_acc;        // Write access cycle
   logic                        rd_flags;      // Status read pulse
   logic                        rd_clip;       // Channel status read
   logic                        rd_gpio;       // GPIO status read
   logic                        w1c_flags;     // Write to status
   logic                        mapped;        // Address decodes
   logic                        trig_edge;     // Overflow edge mode
   logic [`ISM_EVTS-1:0]        evt_vec;       // Event pulses
   logic [`ISM_EVTS-1:0]        evt_clr;       // Edge flag clears
   logic [`ISM_EVTS-1:0]        evt_q;         // Edge flags
   logic [`ISM_CHANS-1:0]       clip_clr;      // Channel clears
   logic [`ISM_CHANS-1:0]       clip_q;        // Channel status
   logic [`ISM_GPIOS-1:0]       gpio_stat;     // GPIO status
   logic                        overflow_irq_flag; // Overflow flag
   logic                        gpio_flag;     // GPIO flag
   logic [7:0]                  flags_vec;     // Status register view
   logic                        pending;       // Interrupt condition
   logic [31:0]                 rd_mux;        // Read data select

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------
   assign idx       = paddr[7:2];
   assign rd_setup  = psel & ~penable & ~pwrite;
   assign wr_acc    = psel & penable & pwrite;
   // Read side effects happen at the setup edge, with the data capture
   // Clear and capture share one edge, so an event landing between
   // them cannot be read as zero and then lost
   assign rd_flags  = rd_setup & (idx == `ISM_IDX_FLAGS);
   assign rd_clip   = rd_setup & (idx == `ISM_IDX_CLIP);
   assign rd_gpio   = rd_setup & (idx == `ISM_IDX_GPIO_STAT);
   assign w1c_flags = wr_acc & (idx == `ISM_IDX_FLAGS);
   // Zero wait state slave
   assign pready    = 1'b1;
   assign prdata    = state_reg.prdata;
   assign pslverr   = state_reg.pslverr;

   // -----------------------------------------------------------------
   // Edge-type event flags
   // -----------------------------------------------------------------
   assign trig_edge = state_reg.mode[`ISM_TRIG_BIT];
   // Bit order of evt_vec: unlock, lock, ramp up, ramp down, mute
   assign evt_vec   = {src_evt.unlock, src_evt.lock, src_evt.ramp_up,
                       src_evt.ramp_down, src_evt.mute};
   // Read, write-one and opposite converter event clear a flag
   always_comb begin
      evt_clr    = {`ISM_EVTS{rd_flags}};
      if (w1c_flags) begin
         evt_clr = evt_clr | pwdata[`ISM_EVT_HI:`ISM_EVT_LO];
      end
      // Both converter events in one cycle leave both flags set
      evt_clr[4] = evt_clr[4] | src_evt.lock;
      evt_clr[3] = evt_clr[3] | src_evt.unlock;
   end

   // Sticky flags, set wins
   ism_sticky_bits #(
      .W (`ISM_EVTS)
   ) u_evt_flags (
      .pclk     (pclk),
      .presetn  (presetn),
      .set_bits (evt_vec),
      .clr_bits (evt_clr),
      .flags    (evt_q)
   );

   // -----------------------------------------------------------------
   // Channel clip status
   // -----------------------------------------------------------------
   // Clip strobes come from pclk logic, so no synchroniser is needed
   // Edge mode clears on read; level mode only once the channel is quiet
   assign clip_clr = {`ISM_CHANS{rd_clip}}
                   & ({`ISM_CHANS{trig_edge}} | ~chan_clip);

   // Per-channel sticky bits
   ism_sticky_bits #(
      .W (`ISM_CHANS)
   ) u_clip_flags (
      .pclk     (pclk),
      .presetn  (presetn),
      .set_bits (chan_clip),
      .clr_bits (clip_clr),
      .flags    (clip_q)
   );

   // -----------------------------------------------------------------
   // GPIO sensing
   // -----------------------------------------------------------------
   // Only the low GPIO inputs can raise the interrupt; all report status
   ism_gpio_sense u_gpio (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (gpio_pin),
      .pol_high  (state_reg.gpio_pol),
      .trig_edge (state_reg.gpio_trig),
      .rd_clr    (rd_gpio),
      .status    (gpio_stat)
   );

   // -----------------------------------------------------------------
   // Flag collection and interrupt condition
   // -----------------------------------------------------------------
   assign overflow_irq_flag = |clip_q;
   assign gpio_flag = |(gpio_stat[`ISM_GPIO_IRQS-1:0]
                        & state_reg.gpio_mask);
   // Status read does not touch overflow or GPIO flags
   assign flags_vec = {evt_q, overflow_irq_flag, gpio_flag, 1'b0};
   // Mask bits line up with the flags they gate
   assign pending   = (|(flags_vec & state_reg.mask)) | gpio_flag;
   assign style     = ism_pkg::ism_pin_style_type'(
                      state_reg.mode[`ISM_STYLE_HI:`ISM_STYLE_LO]);

   // -----------------------------------------------------------------
   // Read data select
   // -----------------------------------------------------------------
   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      case (idx)
         `ISM_IDX_MODE: begin
            rd_mux[7:0] = state_reg.mode;
         end
         `ISM_IDX_MASK: begin
            rd_mux[7:0] = state_reg.mask;
         end
         `ISM_IDX_FLAGS: begin
            rd_mux[7:0] = flags_vec;
         end
         `ISM_IDX_CLIP: begin
            rd_mux[`ISM_CHANS-1:0] = clip_q;
         end
         `ISM_IDX_GPIO_POL: begin
            rd_mux[`ISM_GPIOS-1:0] = state_reg.gpio_pol;
         end
         `ISM_IDX_GPIO_TRIG: begin
            rd_mux[`ISM_GPIOS-1:0] = state_reg.gpio_trig;
         end
         `ISM_IDX_GPIO_STAT: begin
            rd_mux[`ISM_GPIOS-1:0] = gpio_stat;
         end
         `ISM_IDX_GPIO_MASK: begin
            rd_mux[`ISM_GPIO_IRQS-1:0] = state_reg.gpio_mask;
         end
         default: begin
            mapped = 1'b0;   // Unmapped: zero data, error
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // Capture read data and error at the setup edge
      if (psel && !penable) begin
         state_next.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
         state_next.pslverr = ~mapped;
      end
      // Register writes at the access edge
      if (wr_acc) begin
         case (idx)
            `ISM_IDX_MODE: begin
               state_next.mode = pwdata[7:0] & `ISM_MODE_WMASK;
            end
            `ISM_IDX_MASK: begin
               state_next.mask = pwdata[7:0] & `ISM_MASK_WMASK;
            end
            `ISM_IDX_GPIO_POL: begin
               state_next.gpio_pol = pwdata[`ISM_GPIOS-1:0];
            end
            `ISM_IDX_GPIO_TRIG: begin
               state_next.gpio_trig = pwdata[`ISM_GPIOS-1:0];
            end
            `ISM_IDX_GPIO_MASK: begin
               state_next.gpio_mask = pwdata[`ISM_GPIO_IRQS-1:0];
            end
            default: begin
               state_next.mode = state_reg.mode;  // Read-only or unmapped
            end
         endcase
      end
      // Pin drive per style
      // Registered so the host never sees a glitch on the pin
      case (style)
         ism_pkg::ISM_STYLE_HIGH: begin
            state_next.irq_out = pending;
            state_next.irq_oe  = 1'b1;
         end
         ism_pkg::ISM_STYLE_LOW: begin
            state_next.irq_out = ~pending;
            state_next.irq_oe  = 1'b1;
         end
         ism_pkg::ISM_STYLE_OPEN: begin
            state_next.irq_out = 1'b0;
            state_next.irq_oe  = pending;
         end
         default: begin
            state_next.irq_out = 1'b0;   // Reserved: pin released
            state_next.irq_oe  = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg           <= '0;
         state_reg.mode      <= `ISM_MODE_RST;
         state_reg.mask      <= `ISM_MASK_RST;
         state_reg.gpio_pol  <= `ISM_GPOL_RST;
         state_reg.gpio_trig <= `ISM_GTRIG_RST;
         state_reg.gpio_mask <= `ISM_GMASK_RST;
         // High style, deasserted: the pin is driven low
         state_reg.irq_oe    <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end
   assign irq_pin_out = state_reg.irq_out;
   assign irq_pin_oe  = state_reg.irq_oe;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Pin drive: one edge behind the interrupt condition, per style
   a_style_low: assert property (
      (style == ism_pkg::ISM_STYLE_LOW) |=> (irq_pin_oe && irq_pin_out == !$past(pending)))
      else $error("low style pin mismatch");
   a_style_rsvd: assert property (
      (style == ism_pkg::ISM_STYLE_RSVD) |=> !irq_pin_oe)
      else $error("reserved style drove pin");

   a_style_high: assert property (
      (style == ism_pkg::ISM_STYLE_HIGH) |=> (irq_pin_oe && irq_pin_out == $past(pending)))
      else $error("high style pin mismatch");
   a_style_open: assert property (
      (style == ism_pkg::ISM_STYLE_OPEN) |=> (!irq_pin_out && irq_pin_oe == $past(pending)))
      else $error("open drain pin mismatch");
   a_mask_gate: assert property (
      (style == ism_pkg::ISM_STYLE_LOW && !(|(flags_vec & state_reg.mask)) && !gpio_flag)
      |=> irq_pin_out)
      else $error("masked flag drove pin");
   a_gpio_unmask: assert property (
      (gpio_flag && style == ism_pkg::ISM_STYLE_HIGH) |=> irq_pin_out)
      else $error("gpio flag gated by main mask");
   // Flag capture and read-clear behaviour
   a_event_sets: assert property (
      (|evt_vec) |=> ((evt_q & $past(evt_vec)) == $past(evt_vec)))
      else $error("event did not set its flag");
   a_gpio_keep: assert property (
      (rd_flags && gpio_flag) |=> gpio_flag)
      else $error("status read cleared gpio flag");
   a_flags_read: assert property (
      (rd_flags && !penable) |=> (prdata[7:0] == $past(flags_vec)))
      else $error("status read data wrong");
   a_edge_clear: assert property (
      (rd_flags && evt_vec == '0) |=> (evt_q == '0))
      else $error("edge flags not cleared by read");
   a_keep_level: assert property (
      (rd_flags && overflow_irq_flag && !rd_clip) |=> overflow_irq_flag)
      else $error("status read cleared overflow");
   a_clip_edge: assert property (
      (rd_clip && trig_edge && chan_clip == '0) |=> (clip_q == '0))
      else $error("edge clip status not cleared");
   // Channel level or edge handling, lock swaps and set priority
   a_clip_level: assert property (
      (rd_clip && !trig_edge) |=> ((clip_q & $past(chan_clip)) == $past(chan_clip)))
      else $error("level clip cleared while active");
   a_clip_hold: assert property (
      !rd_clip |=> ((clip_q & $past(clip_q)) == $past(clip_q)))
      else $error("clip status lost without read");
   a_lock_swap: assert property (
      (src_evt.lock && !src_evt.unlock) |=> (evt_q[3] && !evt_q[4]))
      else $error("lock did not cancel unlock");
   a_unlock_swap: assert property (
      (src_evt.unlock && !src_evt.lock) |=> (evt_q[4] && !evt_q[3]))
      else $error("unlock did not cancel lock");
   a_set_wins: assert property (
      (rd_flags && src_evt.mute) |=> evt_q[0] ##1 (evt_q[0] || $past(rd_flags)))
      else $error("event lost in clearing cycle");

   // Cover the main scenarios
   c_lock_seen: cover property (src_evt.lock ##1 rd_flags);
   c_clip_irq: cover property ((|chan_clip) ##[1:4] (irq_pin_out && style == ism_pkg::ISM_STYLE_HIGH));
   c_low_irq: cover property (style == ism_pkg::ISM_STYLE_LOW && !irq_pin_out && irq_pin_oe);
   c_gpio_irq: cover property (gpio_flag ##1 rd_gpio);
endmodule

/* File: rtl/ism_params.svh */
/*
 Constants of the interrupt status and mask unit: register indexes,
 field positions, reset values and widths.
 Assumes inclusion by bare name from any design file.
*/
`ifndef ISM_PARAMS_SVH
`define ISM_PARAMS_SVH
// -----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define ISM_IDX_MODE      6'h28
`define ISM_IDX_MASK      6'h29
`define ISM_IDX_FLAGS     6'h2a
`define ISM_IDX_CLIP      6'h2b
`define ISM_IDX_GPIO_POL  6'h2d
`define ISM_IDX_GPIO_TRIG 6'h2e
`define ISM_IDX_GPIO_STAT 6'h2f
`define ISM_IDX_GPIO_MASK 6'h30
// -----------------------------------------------------------------
// Field positions and writable bits
// -----------------------------------------------------------------
`define ISM_STYLE_HI      7
`define ISM_STYLE_LO      6
`define ISM_TRIG_BIT      0
`define ISM_MODE_WMASK    8'hc1
`define ISM_MASK_WMASK    8'hfc
`define ISM_EVT_HI        7
`define ISM_EVT_LO        3
// -----------------------------------------------------------------
// Reset values and widths
// -----------------------------------------------------------------
`define ISM_MODE_RST      8'h00
`define ISM_MASK_RST      8'h00
`define ISM_GPOL_RST      7'h7f
`define ISM_GTRIG_RST     7'h00
`define ISM_GMASK_RST     4'h0
`define ISM_CHANS         6
`define ISM_GPIOS         7
`define ISM_GPIO_IRQS     4
`define ISM_EVTS          5
`endif

/* File: rtl/ism_pkg.sv */
/*
 Types of the interrupt status and mask unit.
 Assumes ism_params.svh is compiled alongside.
*/
package ism_pkg;
   // -----------------------------------------------------------------
   // Output pin style
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ISM_STYLE_HIGH  = 2'b00,
      ISM_STYLE_LOW   = 2'b01,
      ISM_STYLE_OPEN  = 2'b10,
      ISM_STYLE_RSVD  = 2'b11
   } ism_pin_style_type;
   // Single-cycle event pulses from converter and volume ramps
   typedef struct packed {
      logic unlock;
      logic lock;
      logic ramp_up;
      logic ramp_down;
      logic mute;
   } ism_src_evt_type;
   // Whole state of the top module
   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  mask;
      logic [6:0]  gpio_pol;
      logic [6:0]  gpio_trig;
      logic [3:0]  gpio_mask;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq_out;
      logic        irq_oe;
   } ism_state_type;
endpackage

/* File: rtl/ism_sticky_bits.sv */
/*
 Vector of sticky flags: set pulses win over clear pulses.
 Assumes set and clear come from logic on pclk.
*/
`timescale 1ns/1ps
module ism_sticky_bits #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   output logic      [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] q;      // Held flags
   } ism_sticky_type;
   ism_sticky_type state_reg;   // Registered state
   ism_sticky_type state_next;  // Next state
   // -----------------------------------------------------------------
   // Next state: set wins over clear
   // -----------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      state_next.q = (state_reg.q & ~clr_bits) | set_bits;
   end
   // Flags clear on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign flags = state_reg.q;
endmodule

/* File: rtl/ism_gpio_sense.sv */
/*
 GPIO input sensing: two-stage synchroniser, polarity, edge or level
 capture into read-clear status bits.
 Assumes pins are asynchronous to pclk.
*/
`timescale 1ns/1ps
`include "ism_params.svh"
module ism_gpio_sense (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`ISM_GPIOS-1:0]  pin_async,
   input  wire logic [`ISM_GPIOS-1:0]  pol_high,
   input  wire logic [`ISM_GPIOS-1:0]  trig_edge,
   input  wire logic                   rd_clr,
   output logic      [`ISM_GPIOS-1:0]  status
);
   typedef struct packed {
      logic [`ISM_GPIOS-1:0] meta;   // First synchroniser stage
      logic [`ISM_GPIOS-1:0] sync;   // Second synchroniser stage
      logic [`ISM_GPIOS-1:0] act_d;  // Active level one cycle ago
      logic [`ISM_GPIOS-1:0] stat;   // Status bits
   } ism_gpio_type;
   ism_gpio_type            state_reg;  // Registered state
   ism_gpio_type            state_next; // Next state
   logic [`ISM_GPIOS-1:0]   active;     // Pin at its active level
   logic [`ISM_GPIOS-1:0]   set_b;      // Status set terms
   logic [`ISM_GPIOS-1:0]   clr_b;      // Status clear terms
   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      state_next      = state_reg;
      active          = ~(state_reg.sync ^ pol_high);
      // Edge mode sets on entry to active level, level mode while active
      set_b           = (trig_edge & active & ~state_reg.act_d)
                      | (~trig_edge & active);
      // Read clears edge bits, level bits only once inactive
      clr_b           = {`ISM_GPIOS{rd_clr}} & (trig_edge | ~active);
      state_next.meta = pin_async;
      state_next.sync = state_reg.meta;
      state_next.act_d = active;
      state_next.stat = (state_reg.stat & ~clr_b) | set_b;
   end
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign status = state_reg.stat;
endmodule

/* File: sim/ism_host_model.sv */
/*
 Host side of the interrupt pin: resolves the wire level seen by the host.
 Assumes a pull-up on the wire while the unit releases it.
*/
`timescale 1ns/1ps
module ism_host_model (
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pin_level
);
   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // The external pull-up wins whenever the unit stops driving
   assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

/* File: sim/tb.sv */
/*
 Self-checking bench of the interrupt status and mask unit.
 Assumes zero wait APB and the host model on the interrupt pin.
*/
`timescale 1ns/1ps
`include "ism_params.svh"
module tb;
   logic                      pclk;
   logic                      presetn;
   logic                      psel;
   logic                      penable;
   logic                      pwrite;
   logic [7:0]                paddr;
   logic [31:0]               pwdata;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   ism_pkg::ism_src_evt_type  src_evt;
   logic [5:0]                chan_clip;
   logic [6:0]                gpio_pin;
   logic                      irq_pin_out;
   logic                      irq_pin_oe;
   logic                      pin_level;
   logic [31:0]               rdv;
   logic                      errv;
   logic [1:0]                sty;
   int                        fail_count;
   int                        n_checks;
   // ----------------------------------------------------------------
   // Design, host and clock
   // ----------------------------------------------------------------
   ism_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_evt(src_evt), .chan_clip(chan_clip), .gpio_pin(gpio_pin), .irq_pin_out(irq_pin_out),
      .irq_pin_oe(irq_pin_oe));
   ism_host_model host (.pin_out(irq_pin_out), .pin_oe(irq_pin_oe), .pin_level(pin_level));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; ev is pulsed during the setup cycle
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic [4:0] ev);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      src_evt <= ev;
      @(posedge pclk);
      penable <= 1'b1;
      src_evt <= 5'h00;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, 5'h00);
      chk(rdv, exp);
      chk({31'h0, errv}, 32'h0);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 5'h00);
   endtask
   task automatic pulse(input logic [4:0] ev);
      @(posedge pclk);
      src_evt <= ev;
      @(posedge pclk);
      src_evt <= 5'h00;
      repeat (3) @(posedge pclk);
   endtask
   // Pin as the host sees it, asserted or not, in the current style
   task automatic pchk(input logic a);
      @(posedge pclk);
      #1;
      chk({31'h0, pin_level}, {31'h0, a ? (sty == 2'b00) : (sty != 2'b00)});
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(`ISM_IDX_MODE, 32'h00);
      rd(`ISM_IDX_MASK, 32'h00);
      rd(`ISM_IDX_FLAGS, 32'h00);
      rd(`ISM_IDX_GPIO_POL, 32'h7f);
      pchk(1'b0);
      apb(1'b0, 6'h3f, 32'h0, 5'h00);
      chk(rdv, 32'h00);
      chk({31'h0, errv}, 32'h1);
      chk({31'h0, pready}, 32'h1);
      $display("t_reset done");
   endtask
   task automatic t_edges;
      for (int i = 0; i < 5; i++) begin
         pulse(5'h01 << i);
         pchk(1'b0);
         rd(`ISM_IDX_FLAGS, 32'h08 << i);
         rd(`ISM_IDX_FLAGS, 32'h00);
      end
      pulse(5'h02);
      wr(`ISM_IDX_FLAGS, 32'h08);
      rd(`ISM_IDX_FLAGS, 32'h10);
      pulse(5'h02);
      wr(`ISM_IDX_FLAGS, 32'h10);
      rd(`ISM_IDX_FLAGS, 32'h00);
      $display("t_edges done");
   endtask
   task automatic t_style;
      wr(`ISM_IDX_MASK, 32'hf8);
      rd(`ISM_IDX_MASK, 32'hf8);
      for (int s = 0; s < 3; s++) begin
         sty = s[1:0];
         wr(`ISM_IDX_MODE, {24'h0, sty, 6'h00});
         pchk(1'b0);
         pulse(5'h01);
         pchk(1'b1);
         rd(`ISM_IDX_FLAGS, 32'h08);
         pchk(1'b0);
      end
      wr(`ISM_IDX_MODE, 32'hc0);
      pulse(5'h01);
      chk({31'h0, irq_pin_oe}, 32'h0);
      rd(`ISM_IDX_FLAGS, 32'h08);
      sty = 2'b00;
      wr(`ISM_IDX_MODE, 32'h00);
      wr(`ISM_IDX_MASK, 32'h10);
      pulse(5'h01);
      pchk(1'b0);
      rd(`ISM_IDX_FLAGS, 32'h08);
      $display("t_style done");
   endtask
   task automatic t_lock;
      pulse(5'h10);
      pulse(5'h08);
      rd(`ISM_IDX_FLAGS, 32'h40);
      pulse(5'h08);
      pulse(5'h10);
      rd(`ISM_IDX_FLAGS, 32'h80);
      apb(1'b0, `ISM_IDX_FLAGS, 32'h0, 5'h01);
      chk(rdv, 32'h00);
      rd(`ISM_IDX_FLAGS, 32'h08);
      $display("t_lock done");
   endtask
   task automatic t_ovf;
      wr(`ISM_IDX_MASK, 32'h04);
      chan_clip <= 6'h04;
      repeat (3) @(posedge pclk);
      rd(`ISM_IDX_FLAGS, 32'h04);
      rd(`ISM_IDX_FLAGS, 32'h04);
      pchk(1'b1);
      rd(`ISM_IDX_CLIP, 32'h04);
      rd(`ISM_IDX_FLAGS, 32'h04);
      chan_clip <= 6'h00;
      apb(1'b0, `ISM_IDX_CLIP, 32'h0, 5'h00);
      rd(`ISM_IDX_FLAGS, 32'h00);
      wr(`ISM_IDX_MODE, 32'h01);
      rd(`ISM_IDX_MODE, 32'h01);
      chan_clip <= 6'h20;
      @(posedge pclk);
      chan_clip <= 6'h00;
      repeat (2) @(posedge pclk);
      rd(`ISM_IDX_FLAGS, 32'h04);
      rd(`ISM_IDX_CLIP, 32'h20);
      rd(`ISM_IDX_CLIP, 32'h00);
      rd(`ISM_IDX_FLAGS, 32'h00);
      wr(`ISM_IDX_MODE, 32'h00);
      $display("t_ovf done");
   endtask
   task automatic t_gpio;
      wr(`ISM_IDX_MASK, 32'hfc);
      gpio_pin <= 7'h01;
      repeat (5) @(posedge pclk);
      rd(`ISM_IDX_FLAGS, 32'h00);
      rd(`ISM_IDX_GPIO_STAT, 32'h01);
      pchk(1'b0);
      wr(`ISM_IDX_GPIO_MASK, 32'h01);
      pchk(1'b1);
      wr(`ISM_IDX_MASK, 32'h00);
      pchk(1'b1);
      rd(`ISM_IDX_FLAGS, 32'h02);
      gpio_pin <= 7'h00;
      repeat (5) @(posedge pclk);
      apb(1'b0, `ISM_IDX_GPIO_STAT, 32'h0, 5'h00);
      rd(`ISM_IDX_FLAGS, 32'h00);
      pchk(1'b0);
      wr(`ISM_IDX_GPIO_TRIG, 32'h01);
      gpio_pin <= 7'h01;
      repeat (5) @(posedge pclk);
      rd(`ISM_IDX_FLAGS, 32'h02);
      rd(`ISM_IDX_GPIO_STAT, 32'h01);
      rd(`ISM_IDX_FLAGS, 32'h00);
      gpio_pin <= 7'h00;
      repeat (5) @(posedge pclk);
      wr(`ISM_IDX_GPIO_POL, 32'h7e);
      rd(`ISM_IDX_GPIO_STAT, 32'h01);
      rd(`ISM_IDX_GPIO_STAT, 32'h00);
      $display("t_gpio done");
   endtask
   // ----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      src_evt = 5'h00;
      chan_clip = 6'h00;
      gpio_pin = 7'h00;
      sty = 2'b00;
      fail_count = 0;
      n_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_edges();
      t_style();
      t_lock();
      t_ovf();
      t_gpio();
      stop_test();
   end
endmodule
